// ===== verilog/ofm_consts.svh
// Purpose: register map, codes and counts of the oscillator frequency monitor
// Assumes: clk_in is the on-chip reference clock at 20 MHz
// Notes:   byte addresses on the plain register port, one word per register
//
// Functional notes
// - enable and limit writes need the unlock key
// - enable code under key starts monitoring
// - limits frozen while monitoring runs
// - pin, power-on, low-voltage reset clear all
// - own reset never clears this block
// - PLL select picks the limit pair
// - own reset under PLL forces PLL-off pair
// - fault resets CPU, clocks, floats I/O
// - two periods of 128 cycles before first decision
// - reset one period after bad period
// - STOP suspends; resume after warm-up ends
// - fault reset only in NORMAL or IDLE
// - limit equals reference times value over 32
`ifndef OFM_CONSTS_SVH
`define OFM_CONSTS_SVH

`define OFM_ADDR_W          8
`define OFM_DATA_W          32
`define OFM_LIM_W           8
`define OFM_CNT_W           10
`define OFM_WIN_W           7

`define OFM_ADDR_KEY        8'h00
`define OFM_ADDR_ENABLE     8'h04
`define OFM_ADDR_LO_OFF     8'h08
`define OFM_ADDR_LO_ON      8'h0c
`define OFM_ADDR_HI_OFF     8'h10
`define OFM_ADDR_HI_ON      8'h14
`define OFM_ADDR_STATUS     8'h18
`define OFM_ADDR_CLEAR      8'h1c
`define OFM_ADDR_IRQ_EN     8'h20

`define OFM_KEY_UNLOCK      8'hf9
`define OFM_KEY_LOCK        8'h06
`define OFM_ENABLE_CODE     8'he4

`define OFM_KEY_RESET       8'h00
`define OFM_ENABLE_RESET    8'h00
`define OFM_LIMIT_RESET     8'h00
`define OFM_IRQ_RESET       3'h0

`define OFM_STAT_RANGE_BIT  0
`define OFM_STAT_RESET_BIT  1
`define OFM_STAT_REFUSE_BIT 2
`define OFM_STAT_W          3

`define OFM_PERIOD_CYCLES   7'h7f
`define OFM_LIMIT_SHIFT     2
`define OFM_RST_HOLD        6'h20

`endif

// ===== verilog/ofm_pkg.sv
// Purpose: shared types of the oscillator frequency monitor
// Assumes: nothing
// Notes:   one-hot state codes
package ofm_pkg;
    typedef enum logic [5:0] {
        OFM_IDLE    = 6'h01,
        OFM_RUN     = 6'h02,
        OFM_PEND    = 6'h04,
        OFM_RESET   = 6'h08,
        OFM_STOP    = 6'h10,
        OFM_WARMUP  = 6'h20
    } ofm_state_t;
endpackage

// ===== verilog/ofm_pin_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: input comes from another clock domain
// Notes:   output changes once stages two and three agree
`timescale 1ns/1ps
module ofm_pin_sync (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic pin_in,
    output logic      level_out
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s1_r      <= 1'b0;
            s2_r      <= 1'b0;
            s3_r      <= 1'b0;
            level_out <= 1'b0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_out <= s3_r;
            end
        end
    end
endmodule

// ===== verilog/ofm_top.sv
// Purpose: oscillator frequency monitor, counts target edges per reference window
// Assumes: target clock below a quarter of the reference clock; rst_n_in is pin/POR/LVD reset
// Notes:   fault reset is an output only and never resets this block
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "ofm_consts.svh"
module ofm_top
    import ofm_pkg::*;
(
    input  wire logic                    clk_in,
    input  wire logic                    rst_n_in,
    input  wire logic [`OFM_ADDR_W-1:0]  addr_in,
    input  wire logic [`OFM_DATA_W-1:0]  wr_data_in,
    input  wire logic                    wr_strobe_in,
    input  wire logic                    rd_strobe_in,
    output logic      [`OFM_DATA_W-1:0]  rd_data_out,
    input  wire logic                    target_clk_in,
    input  wire logic                    pll_select_bit_in,
    input  wire logic                    stop_mode_in,
    input  wire logic                    warmup_done_in,
    input  wire logic                    normal_idle_in,
    output logic                         sys_reset_out,
    output logic                         io_hiz_out,
    output logic                         irq_out
);
    ofm_state_t                state_r;
    ofm_state_t                state_nxt;
    logic [7:0]                key_r;
    logic [7:0]                enable_r;
    logic [`OFM_LIM_W-1:0]     lo_off_r;
    logic [`OFM_LIM_W-1:0]     lo_on_r;
    logic [`OFM_LIM_W-1:0]     hi_off_r;
    logic [`OFM_LIM_W-1:0]     hi_on_r;
    logic [`OFM_STAT_W-1:0]    status_r;
    logic [`OFM_STAT_W-1:0]    status_nxt;
    logic [`OFM_STAT_W-1:0]    irq_en_r;
    logic [`OFM_WIN_W-1:0]     win_r;
    logic [`OFM_CNT_W-1:0]     edges_r;
    logic [`OFM_CNT_W-1:0]     edges_nxt;
    logic                      seen_r;
    logic                      forced_off_r;
    logic [5:0]                hold_r;
    logic                      tgt_lvl;
    logic                      tgt_prev_r;

    function automatic logic hit(input logic [`OFM_ADDR_W-1:0] a,
                                 input logic [`OFM_ADDR_W-1:0] b);
        hit = (a == b);
    endfunction

    function automatic logic [`OFM_CNT_W-1:0] to_edges(input logic [`OFM_LIM_W-1:0] v);
        to_edges = {v, {`OFM_LIMIT_SHIFT{1'b0}}};
    endfunction

    ofm_pin_sync u_sync (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .pin_in    (target_clk_in),
        .level_out (tgt_lvl)
    );

    // register decode
    wire unlocked   = (key_r == `OFM_KEY_UNLOCK);
    wire mon_on     = (enable_r == `OFM_ENABLE_CODE);
    wire wr_key     = wr_strobe_in && hit(addr_in, `OFM_ADDR_KEY);
    wire wr_enable  = wr_strobe_in && hit(addr_in, `OFM_ADDR_ENABLE);
    wire wr_limit   = wr_strobe_in && (hit(addr_in, `OFM_ADDR_LO_OFF)
                    || hit(addr_in, `OFM_ADDR_LO_ON) || hit(addr_in, `OFM_ADDR_HI_OFF)
                    || hit(addr_in, `OFM_ADDR_HI_ON));
    wire en_ok      = wr_enable && unlocked;
    wire lim_ok     = wr_limit && unlocked && !mon_on;
    wire refused    = (wr_enable && !unlocked) || (wr_limit && !lim_ok);
    wire start_mon  = en_ok && (wr_data_in[7:0] == `OFM_ENABLE_CODE);
    wire stop_mon   = en_ok && (wr_data_in[7:0] != `OFM_ENABLE_CODE);

    // limit pair selection
    wire use_on     = pll_select_bit_in && !forced_off_r;
    wire [`OFM_LIM_W-1:0] sel_lo = use_on ? lo_on_r : lo_off_r;
    wire [`OFM_LIM_W-1:0] sel_hi = use_on ? hi_on_r : hi_off_r;

    // measurement window
    wire active     = state_r == OFM_RUN || state_r == OFM_PEND || state_r == OFM_RESET;
    wire tgt_edge   = tgt_lvl && !tgt_prev_r;
    wire win_end    = active && (win_r == `OFM_PERIOD_CYCLES);
    wire [`OFM_CNT_W-1:0] final_edges = edges_r + {{(`OFM_CNT_W-1){1'b0}}, tgt_edge};
    wire out_range  = (final_edges < to_edges(sel_lo))
                    || (final_edges > to_edges(sel_hi));
    wire decide     = win_end && seen_r;
    wire bad_period = decide && out_range && state_r == OFM_RUN;
    wire hold_done  = (hold_r == `OFM_RST_HOLD);

    assign edges_nxt = win_end ? {`OFM_CNT_W{1'b0}} : final_edges;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            OFM_IDLE: begin
                if (start_mon) begin
                    state_nxt = stop_mode_in ? OFM_STOP : OFM_RUN;
                end
            end
            OFM_RUN: begin
                if (bad_period && normal_idle_in) begin
                    state_nxt = OFM_PEND;
                end
            end
            OFM_PEND: begin
                if (win_end) begin
                    state_nxt = normal_idle_in ? OFM_RESET : OFM_RUN;
                end
            end
            OFM_RESET: begin
                if (hold_done) begin
                    state_nxt = OFM_RUN;
                end
            end
            OFM_STOP: begin
                if (!stop_mode_in) begin
                    state_nxt = OFM_WARMUP;
                end
            end
            OFM_WARMUP: begin
                if (warmup_done_in) begin
                    state_nxt = OFM_RUN;
                end
            end
            default: begin
                state_nxt = OFM_IDLE;
            end
        endcase
        if (stop_mon || !mon_on && !start_mon) begin
            state_nxt = OFM_IDLE;
        end else if (stop_mode_in && state_r != OFM_IDLE && state_r != OFM_STOP) begin
            state_nxt = OFM_STOP;
        end
    end

    // sticky events, set beats clear
    wire clr_wr = wr_strobe_in && hit(addr_in, `OFM_ADDR_CLEAR);
    wire [`OFM_STAT_W-1:0] ev_set = {refused, state_nxt == OFM_RESET && state_r != OFM_RESET,
                                     bad_period};
    assign status_nxt = (status_r & ~(clr_wr ? wr_data_in[`OFM_STAT_W-1:0]
                        : {`OFM_STAT_W{1'b0}})) | ev_set;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_r  <= OFM_IDLE;
            key_r    <= `OFM_KEY_RESET;
            enable_r <= `OFM_ENABLE_RESET;
            status_r <= `OFM_IRQ_RESET;
            irq_en_r <= `OFM_IRQ_RESET;
        end else begin
            state_r  <= state_nxt;
            status_r <= status_nxt;
            if (wr_key) begin
                key_r <= wr_data_in[7:0];
            end
            if (en_ok) begin
                enable_r <= wr_data_in[7:0];
            end
            if (wr_strobe_in && hit(addr_in, `OFM_ADDR_IRQ_EN)) begin
                irq_en_r <= wr_data_in[`OFM_STAT_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            lo_off_r <= `OFM_LIMIT_RESET;
            lo_on_r  <= `OFM_LIMIT_RESET;
            hi_off_r <= `OFM_LIMIT_RESET;
            hi_on_r  <= `OFM_LIMIT_RESET;
        end else if (lim_ok) begin
            if (hit(addr_in, `OFM_ADDR_LO_OFF)) lo_off_r <= wr_data_in[`OFM_LIM_W-1:0];
            if (hit(addr_in, `OFM_ADDR_LO_ON))  lo_on_r  <= wr_data_in[`OFM_LIM_W-1:0];
            if (hit(addr_in, `OFM_ADDR_HI_OFF)) hi_off_r <= wr_data_in[`OFM_LIM_W-1:0];
            if (hit(addr_in, `OFM_ADDR_HI_ON))  hi_on_r  <= wr_data_in[`OFM_LIM_W-1:0];
        end
    end

    // window counter, edge counter and first-decision flag
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !active) begin
            win_r      <= {`OFM_WIN_W{1'b0}};
            edges_r    <= {`OFM_CNT_W{1'b0}};
            seen_r     <= 1'b0;
            tgt_prev_r <= 1'b0;
        end else begin
            tgt_prev_r <= tgt_lvl;
            win_r      <= win_r + 7'h01;
            edges_r    <= edges_nxt;
            if (state_r == OFM_RESET) begin
                seen_r <= 1'b0;
            end else if (win_end) begin
                seen_r <= 1'b1;
            end
        end
    end

    // fault reset hold and PLL-off override
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            hold_r       <= 6'h00;
            forced_off_r <= 1'b0;
        end else begin
            hold_r <= (state_r == OFM_RESET) ? hold_r + 6'h01 : 6'h00;
            if (state_r == OFM_PEND && state_nxt == OFM_RESET && use_on) begin
                forced_off_r <= 1'b1;
            end else if (!pll_select_bit_in) begin
                forced_off_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sys_reset_out <= 1'b0;
            io_hiz_out    <= 1'b0;
            irq_out       <= 1'b0;
        end else begin
            sys_reset_out <= (state_nxt == OFM_RESET);
            io_hiz_out    <= (state_nxt == OFM_RESET);
            irq_out       <= |(status_nxt & irq_en_r);
        end
    end

    // read port
    wire [`OFM_DATA_W-1:0] rd_mux =
        hit(addr_in, `OFM_ADDR_KEY)    ? {24'h000000, key_r} :
        hit(addr_in, `OFM_ADDR_ENABLE) ? {24'h000000, enable_r} :
        hit(addr_in, `OFM_ADDR_LO_OFF) ? {24'h000000, lo_off_r} :
        hit(addr_in, `OFM_ADDR_LO_ON)  ? {24'h000000, lo_on_r} :
        hit(addr_in, `OFM_ADDR_HI_OFF) ? {24'h000000, hi_off_r} :
        hit(addr_in, `OFM_ADDR_HI_ON)  ? {24'h000000, hi_on_r} :
        hit(addr_in, `OFM_ADDR_STATUS) ? {29'h0000000, status_r} :
        hit(addr_in, `OFM_ADDR_IRQ_EN) ? {29'h0000000, irq_en_r} : 32'h00000000;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rd_data_out <= 32'h00000000;
        end else begin
            rd_data_out <= rd_strobe_in ? rd_mux : 32'h00000000;
        end
    end

    // checks
    sequence s_start;
        state_r == OFM_IDLE && start_mon && !stop_mode_in;
    endsequence

    sequence s_bad_then_window;
        state_r == OFM_RUN && bad_period && normal_idle_in ##1 state_r == OFM_PEND;
    endsequence

    a_key_guard: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_enable && !unlocked |=> $stable(enable_r))
        else $error("enable register changed without key");

    a_enable_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_start |=> state_r == OFM_RUN && mon_on)
        else $error("monitor did not start on enable code");

    a_limit_lock: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_limit && mon_on |=> $stable(lo_off_r) && $stable(lo_on_r)
                               && $stable(hi_off_r) && $stable(hi_on_r))
        else $error("limit written while monitoring");

    a_reset_delay: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_bad_then_window |-> ##128 ($rose(sys_reset_out) || !normal_idle_in
                              || !mon_on || stop_mode_in))
        else $error("fault reset not one period after bad window");

    a_reset_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(sys_reset_out) && mon_on |-> (sys_reset_out && io_hiz_out)[*8])
        else $error("fault reset too short or pins not floated");

    a_hold_exact: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(sys_reset_out) |-> ##32 (sys_reset_out || !mon_on || stop_mode_in)
                                 ##1 (!sys_reset_out || !mon_on || stop_mode_in))
        else $error("fault reset hold length wrong");

    a_mode_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(sys_reset_out) |-> $past(normal_idle_in))
        else $error("fault reset outside normal or idle");

    a_pair_forced: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(sys_reset_out) && pll_select_bit_in
            |-> !use_on && sel_lo == lo_off_r && sel_hi == hi_off_r)
        else $error("pll-on pair used after fault reset");

    a_stop_suspend: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        stop_mode_in && mon_on && !en_ok |=> state_r == OFM_STOP && !sys_reset_out)
        else $error("monitor not suspended in stop");

    a_first_window: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_start |=> !bad_period [*8])
        else $error("decision during settling periods");

    a_first_decide: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_start |-> ##128 ((win_end && !seen_r) || !mon_on || stop_mode_in))
        else $error("first window end already armed a decision");

    a_disable_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        stop_mon |=> state_r == OFM_IDLE ##1 !sys_reset_out && win_r == 7'h00)
        else $error("disable did not clear detection");
endmodule

// ===== tb/ofm_osc_model.sv
// Purpose: model of the monitored oscillator
// Assumes: half period in ns is set by the bench
// Notes:   free running, as a crystal oscillator is
`timescale 1ns/1ps
module ofm_osc_model (
    input  wire logic [15:0] half_ns_in,
    output logic             clk_out
);
    initial clk_out = 1'b0;
    // half period sets the edge count per window
    always begin
        if (half_ns_in == 16'd0) begin
            #10;
        end else begin
            #(half_ns_in);
        end
        clk_out = ~clk_out;
    end
endmodule

// ===== tb/tb_top.sv
// Purpose: self-checking bench of the frequency monitor
// Assumes: 20 MHz reference, window of 128 cycles
// Notes:   limits 6/10 give 3.75..6.25 MHz, target runs at 5 or 2 MHz
`timescale 1ns/1ps
`include "ofm_consts.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_top;
    import ofm_pkg::*;
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [7:0]  addr_in = 8'h00;
    logic [31:0] wr_data_in = 32'h0;
    logic        wr_strobe_in = 1'b0;
    logic        rd_strobe_in = 1'b0;
    logic        pll_in = 1'b0;
    logic        stop_in = 1'b0;
    logic        warm_in = 1'b0;
    logic        nidle_in = 1'b1;
    logic [15:0] osc_half = 16'd100;
    logic [31:0] rd_data_out;
    logic        target_clk;
    logic        sys_reset_out;
    logic        io_hiz_out;
    logic        irq_out;
    int          mismatches = 0;
    int          check_count = 0;
    int          n;
    int          i;

    always #25 clk_in = ~clk_in;

    ofm_osc_model osc (.half_ns_in(osc_half), .clk_out(target_clk));

    ofm_top dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_strobe_in(wr_strobe_in),
        .rd_strobe_in(rd_strobe_in), .rd_data_out(rd_data_out),
        .target_clk_in(target_clk), .pll_select_bit_in(pll_in),
        .stop_mode_in(stop_in), .warmup_done_in(warm_in),
        .normal_idle_in(nidle_in), .sys_reset_out(sys_reset_out),
        .io_hiz_out(io_hiz_out), .irq_out(irq_out)
    );

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_strobe_in <= 1'b1;
        @(posedge clk_in);
        wr_strobe_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string nm);
        @(posedge clk_in);
        addr_in <= a;
        rd_strobe_in <= 1'b1;
        @(posedge clk_in);
        rd_strobe_in <= 1'b0;
        @(negedge clk_in);
        `CHK(nm, e, rd_data_out & m)
    endtask

    // cycles until the fault reset rises, bounded
    task automatic wait_rise(output int c);
        c = 0;
        while (sys_reset_out !== 1'b1 && c < 2000) begin
            @(negedge clk_in);
            c++;
        end
    endtask

    // cycles with fault reset high over a span
    task automatic quiet(input int span, output int hits);
        hits = 0;
        repeat (span) begin
            @(negedge clk_in);
            if (sys_reset_out !== 1'b0) hits++;
        end
        @(posedge clk_in);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #(20000 * 50);
        mismatches++;
        test_done();
    end

    initial begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (i = 0; i < 9; i++) begin
            rd(8'(i * 4), '1, 32'h0, "reset_value");
        end
        rd(8'h40, '1, 32'h0, "unmapped_read");
        $display("test reset done");

        wr(`OFM_ADDR_LO_OFF, 32'h06);
        rd(`OFM_ADDR_LO_OFF, 32'hff, 32'h0, "unkeyed_limit");
        rd(`OFM_ADDR_STATUS, 32'h7, 32'h4, "refuse_flag");
        wr(`OFM_ADDR_CLEAR, 32'h7);
        rd(`OFM_ADDR_STATUS, 32'h7, 32'h0, "status_clear");
        wr(`OFM_ADDR_KEY, 32'hf9);
        wr(`OFM_ADDR_LO_OFF, 32'h06);
        wr(`OFM_ADDR_HI_OFF, 32'h0a);
        wr(`OFM_ADDR_LO_ON, 32'h14);
        wr(`OFM_ADDR_HI_ON, 32'h1e);
        rd(`OFM_ADDR_HI_ON, 32'hff, 32'h1e, "limit_write");
        wr(`OFM_ADDR_ENABLE, 32'he4);
        rd(`OFM_ADDR_ENABLE, 32'hff, 32'he4, "enable_set");
        wr(`OFM_ADDR_LO_OFF, 32'h01);
        rd(`OFM_ADDR_LO_OFF, 32'hff, 32'h06, "frozen_limit");
        wr(`OFM_ADDR_KEY, 32'h06);
        wr(`OFM_ADDR_ENABLE, 32'h00);
        rd(`OFM_ADDR_ENABLE, 32'hff, 32'he4, "locked_enable");
        wr(`OFM_ADDR_KEY, 32'hf9);
        quiet(1000, n);
        `CHK("in_range_quiet", 0, n)
        $display("test guard and range done");

        wr(`OFM_ADDR_ENABLE, 32'h00);
        rd(`OFM_ADDR_ENABLE, 32'hff, 32'h00, "enable_stop");
        @(posedge clk_in);
        pll_in <= 1'b1;
        wr(`OFM_ADDR_IRQ_EN, 32'h2);
        wr(`OFM_ADDR_ENABLE, 32'he4);
        wait_rise(n);
        `CHK("fault_delay", 1'b1, n >= 378 && n <= 396)
        `CHK("io_float", 1'b1, io_hiz_out)
        n = 0;
        while (sys_reset_out === 1'b1 && n < 100) begin
            n++;
            @(negedge clk_in);
        end
        `CHK("fault_hold", 33, n)
        @(negedge clk_in);
        `CHK("irq_raised", 1'b1, irq_out)
        rd(`OFM_ADDR_STATUS, 32'h2, 32'h2, "fault_flag");
        rd(`OFM_ADDR_ENABLE, 32'hff, 32'he4, "kept_enable");
        rd(`OFM_ADDR_LO_ON, 32'hff, 32'h14, "kept_limit");
        wr(`OFM_ADDR_CLEAR, 32'h7);
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        `CHK("irq_cleared", 1'b0, irq_out)
        quiet(1000, n);
        `CHK("pll_off_pair", 0, n)
        $display("test fault reset done");

        wr(`OFM_ADDR_ENABLE, 32'h00);
        pll_in <= 1'b0;
        osc_half <= 16'd250;
        nidle_in <= 1'b0;
        wr(`OFM_ADDR_CLEAR, 32'h7);
        wr(`OFM_ADDR_ENABLE, 32'he4);
        quiet(1000, n);
        `CHK("mode_block", 0, n)
        rd(`OFM_ADDR_STATUS, 32'h1, 32'h1, "range_flag");
        $display("test mode gate done");

        wr(`OFM_ADDR_ENABLE, 32'h00);
        nidle_in <= 1'b1;
        stop_in <= 1'b1;
        wr(`OFM_ADDR_ENABLE, 32'he4);
        quiet(1000, n);
        `CHK("stop_quiet", 0, n)
        stop_in <= 1'b0;
        quiet(60, n);
        `CHK("warmup_quiet", 0, n)
        warm_in <= 1'b1;
        wait_rise(n);
        `CHK("resume_delay", 1'b1, n >= 378 && n <= 400)
        $display("test stop done");

        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(negedge clk_in);
        `CHK("reset_drops_fault", 1'b0, sys_reset_out)
        rd(`OFM_ADDR_ENABLE, 32'hff, 32'h0, "enable_cleared");
        rd(`OFM_ADDR_KEY, 32'hff, 32'h0, "key_cleared");
        rd(`OFM_ADDR_HI_ON, 32'hff, 32'h0, "limit_cleared");
        $display("test second reset done");
        test_done();
    end
endmodule
